// ### hdl/ubm_breakpoint_matcher.sv
`timescale 1ns/1ns
module ubm_breakpoint_matcher
  import ubm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic [15:0] breakAddressHigh,
  input  wire logic [15:0] breakAddressLow,
  input  wire logic [7:0]  breakCycleSelect,
  input  wire logic        busValid,
  input  wire logic        busDma,
  input  wire logic        busFetch,
  input  wire logic        busWrite,
  input  wire logic [1:0]  busSize,
  input  wire logic [31:0] busAddr,
  input  wire logic        fetchPair,
  input  wire logic        fetchOverrun,
  input  wire logic        fetchBranchDest,
  input  wire logic [3:0]  coreMaskLevel,
  input  wire logic        breakAck,
  input  wire logic        higherExcDecode,
  output logic             breakRequest,
  output logic [3:0]       breakLevel,
  output logic             breakAcceptable,
  output logic [31:0]      breakPc
);

  // ************************************************************
  // Condition decode
  // ************************************************************
  logic [31:0] targetAddr;
  logic [1:0]  cycSel;
  logic [1:0]  fdSel;
  logic [1:0]  dirSel;
  logic [1:0]  sizeSel;
  logic        cycHit;
  logic        dirHit;
  logic        fetchSelHit;
  logic        dataSelHit;
  logic        sizeHit;
  logic        groupsSet;

  always_comb
  begin
    targetAddr = {breakAddressHigh, breakAddressLow};
    cycSel     = breakCycleSelect[CYC_SEL_POS +: 2];
    fdSel      = breakCycleSelect[FD_SEL_POS +: 2];
    dirSel     = breakCycleSelect[DIR_SEL_POS +: 2];
    sizeSel    = breakCycleSelect[SIZE_SEL_POS +: 2];
    // A zero CPU/DMA, fetch/data or read/write group disables the whole condition.
    groupsSet  = (cycSel != SEL_NONE) && (fdSel != SEL_NONE) &&
                 (dirSel != SEL_NONE);
    // Size 00 means size is no condition; fetches report word.
    sizeHit    = (sizeSel == SEL_NONE) || (sizeSel == busSize);
  end

  // CPU/DMA and read/write fields share one decoder shape.
  ubm_field_match uCycField
  (
    .sel      (cycSel),
    .isFirst  (~busDma),
    .isSecond (busDma),
    .hit      (cycHit)
  );

  ubm_field_match uDirField
  (
    .sel      (dirSel),
    .isFirst  (~busWrite),
    .isSecond (busWrite),
    .hit      (dirHit)
  );

  // Overrun fetches are steered to the data option only.
  // Both overrun shapes of a taken branch ride on one flag.
  // Destinations of non-delayed branches never fetch-break.
  ubm_field_match uFetchField
  (
    .sel      (fdSel),
    .isFirst  (busFetch & ~fetchOverrun & ~fetchBranchDest),
    .isSecond (1'b0),
    .hit      (fetchSelHit)
  );

  // An overrun fetch is seen by the data option as a data read.
  ubm_field_match uDataField
  (
    .sel      (fdSel),
    .isFirst  (1'b0),
    .isSecond (~busFetch | fetchOverrun),
    .hit      (dataSelHit)
  );

  // ************************************************************
  // Address compare for the cycle and for a paired second fetch
  // ************************************************************
  logic        typeHit;
  logic        firstHit;
  logic        secondHit;
  logic        matchAny;
  logic [31:0] matchPc;
  logic [31:0] secondAddr;

  always_comb
  begin
    // DMA never fetches and fetches never write, so those
    // combinations fall out of the field decode.
    typeHit    = busValid && groupsSet && cycHit && dirHit && sizeHit &&
                 (fetchSelHit || dataSelHit);
    secondAddr = busAddr + FETCH_STEP;
    // Full-width compare: odd targets miss even fetches and word
    // accesses.
    firstHit   = typeHit && (busAddr == targetAddr);
    // The second instruction of a pair is judged in the same cycle,
    // so later reprogramming cannot cancel it.
    secondHit  = typeHit && busFetch && fetchPair &&
                 (secondAddr == targetAddr);
    matchAny   = firstHit || secondHit;
    matchPc    = firstHit ? busAddr : secondAddr;
  end

  // ************************************************************
  // Pending request toward the interrupt controller
  // ************************************************************
  ubm_state_t  state;
  ubm_state_t  next_state;
  logic        next_breakRequest;
  logic [31:0] next_breakPc;
  logic        next_breakAcceptable;

  always_comb
  begin
    next_state   = state;
    next_breakPc = breakPc;
    case (state)
      UBM_IDLE:
      begin
        if (matchAny)
        begin
          // Saved PC is the matched bus address, or busAddr + FETCH_STEP for a pair's second fetch.
          next_state   = UBM_PEND;
          next_breakPc = matchPc;
        end
      end
      UBM_PEND:
      begin
        // A new match in the clearing cycle wins over the clear.
        if (matchAny)
        begin
          next_breakPc = matchPc;
        end
        // The core takes the break at the next instruction boundary
        // that accepts interrupts.
        else if (breakAck)
        begin
          next_state = UBM_IDLE;
        end
        // A higher-priority exception in decode drops the break.
        else if (higherExcDecode)
        begin
          next_state = UBM_IDLE;
        end
      end
      default:
      begin
        next_state = UBM_IDLE;
      end
    endcase
    next_breakRequest    = (next_state == UBM_PEND);
    // Held pending while the mask is at the break level.
    next_breakAcceptable = next_breakRequest &&
                           (coreMaskLevel <= MASK_LIMIT);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state           <= UBM_IDLE;
      breakRequest    <= 1'b0;
      breakAcceptable <= 1'b0;
      breakPc         <= PC_RESET;
      breakLevel      <= BREAK_LEVEL;
    end
    else if (clkEn)
    begin
      state           <= next_state;
      breakRequest    <= next_breakRequest;
      breakAcceptable <= next_breakAcceptable;
      breakPc         <= next_breakPc;
      breakLevel      <= BREAK_LEVEL;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_fetchBreak;
    @(posedge sys_clk) disable iff (reset)
    clkEn && busValid && busFetch && !busDma && !busWrite &&
    !fetchOverrun && !fetchBranchDest && !fetchPair &&
    breakCycleSelect == 8'h54 && busAddr == targetAddr
    |=> breakRequest && breakPc == $past(busAddr);
  endproperty
  a_fetchBreak: assert property (p_fetchBreak)
    else $error("fetch match did not raise break with its address");

  property p_fetchWriteNever;
    @(posedge sys_clk) disable iff (reset)
    clkEn && busFetch && !fetchOverrun && fdSel == 2'h1 &&
    dirSel == 2'h2 |-> !matchAny;
  endproperty
  a_fetchWriteNever: assert property (p_fetchWriteNever)
    else $error("fetch matched a write-only condition");

  property p_oddWordNever;
    @(posedge sys_clk) disable iff (reset)
    clkEn && !busFetch && busSize == SIZE_WORD && !busAddr[0] &&
    targetAddr[0] |-> !firstHit;
  endproperty
  a_oddWordNever: assert property (p_oddWordNever)
    else $error("even word access matched an odd target");

  property p_dmaFetchNever;
    @(posedge sys_clk) disable iff (reset)
    clkEn && busDma && cycSel == 2'h2 && fdSel == 2'h1 |-> !matchAny;
  endproperty
  a_dmaFetchNever: assert property (p_dmaFetchNever)
    else $error("DMA cycle matched a fetch-only condition");

  property p_overrunData;
    @(posedge sys_clk) disable iff (reset)
    clkEn && busValid && busFetch && fetchOverrun &&
    busAddr == targetAddr && groupsSet && cycHit && dirHit && sizeHit
    |-> (matchAny == fdSel[1]);
  endproperty
  a_overrunData: assert property (p_overrunData)
    else $error("overrun fetch break not decided by data select");

  property p_branchDest;
    @(posedge sys_clk) disable iff (reset)
    clkEn && busFetch && fetchBranchDest && !fdSel[1] && !fetchPair
    |-> !matchAny;
  endproperty
  a_branchDest: assert property (p_branchDest)
    else $error("branch destination fetch raised a fetch break");

  property p_zeroGroup;
    @(posedge sys_clk) disable iff (reset)
    clkEn && !breakRequest && !groupsSet ##1 clkEn |-> !breakRequest;
  endproperty
  a_zeroGroup: assert property (p_zeroGroup)
    else $error("break raised with a zero select group");

  property p_pairHold;
    @(posedge sys_clk) disable iff (reset)
    clkEn && secondHit && !firstHit
    |=> breakRequest && breakPc == $past(busAddr) + FETCH_STEP;
  endproperty
  a_pairHold: assert property (p_pairHold)
    else $error("second fetch of a pair lost its break");

  property p_pendHold;
    @(posedge sys_clk) disable iff (reset)
    breakRequest && clkEn && !breakAck && !higherExcDecode
    |=> breakRequest;
  endproperty
  a_pendHold: assert property (p_pendHold)
    else $error("pending break vanished without acceptance");

  property p_level;
    @(posedge sys_clk) disable iff (reset)
    breakAcceptable && $past(clkEn) |-> breakRequest &&
    breakLevel == 4'hF && $past(coreMaskLevel) <= 4'hE;
  endproperty
  a_level: assert property (p_level)
    else $error("break offered above mask limit or wrong level");

  property p_lost;
    @(posedge sys_clk) disable iff (reset)
    clkEn && breakRequest && higherExcDecode && !matchAny && !breakAck
    |=> !breakRequest;
  endproperty
  a_lost: assert property (p_lost)
    else $error("break survived a higher-priority exception");

  c_fetchBreak: cover property (@(posedge sys_clk) disable iff (reset)
    clkEn && firstHit && busFetch);
  c_pairBreak: cover property (@(posedge sys_clk) disable iff (reset)
    clkEn && secondHit && !firstHit);
  c_dmaBreak: cover property (@(posedge sys_clk) disable iff (reset)
    clkEn && firstHit && busDma && busSize == SIZE_LONG);
  c_ackCycle: cover property (@(posedge sys_clk) disable iff (reset)
    breakRequest ##1 breakAck ##1 !breakRequest);

endmodule // ubm_breakpoint_matcher

// ### hdl/ubm_field_match.sv
`timescale 1ns/1ns
// Two-bit select field: 01 takes the first option, 10 the second,
// 11 both, and 00 nothing.
module ubm_field_match
  import ubm_pkg::*;
(
  input  wire logic [1:0] sel,
  input  wire logic       isFirst,
  input  wire logic       isSecond,
  output logic            hit
);

  always_comb
  begin
    hit = (sel[0] & isFirst) | (sel[1] & isSecond);
  end

endmodule // ubm_field_match

// ### hdl/ubm_pkg.sv
package ubm_pkg;

  // ************************************************************
  // Bus-cycle select byte layout
  // ************************************************************
  localparam int unsigned CYC_SEL_POS  = 6;
  localparam int unsigned FD_SEL_POS   = 4;
  localparam int unsigned DIR_SEL_POS  = 2;
  localparam int unsigned SIZE_SEL_POS = 0;
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam logic [1:0]  SEL_NONE     = 2'h0;

  // ************************************************************
  // Operand sizes as reported with a bus cycle
  // ************************************************************
  localparam logic [1:0]  SIZE_BYTE    = 2'h1;
  localparam logic [1:0]  SIZE_WORD    = 2'h2;
  localparam logic [1:0]  SIZE_LONG    = 2'h3;

  // ************************************************************
  // Interrupt level and fetch geometry
  // ************************************************************
  localparam logic [3:0]  BREAK_LEVEL  = 4'hF;
  localparam logic [3:0]  MASK_LIMIT   = 4'hE;
  localparam logic [31:0] FETCH_STEP   = 32'h0000_0002;
  localparam logic [31:0] PC_RESET     = 32'h0000_0000;

  typedef enum logic [1:0] {
    UBM_IDLE = 2'b01,
    UBM_PEND = 2'b10
  } ubm_state_t;

endpackage

// ### tb/ubm_breakpoint_matcher_tb.sv
`timescale 1ns/1ns
module ubm_breakpoint_matcher_tb;
  import ubm_pkg::*;

  typedef struct packed {
    logic [31:0] tgt;
    logic [7:0]  sel;
    logic [31:0] adr;
    logic [4:0]  flg;
    logic [1:0]  sz;
    logic        hit;
  } ubm_row_t;

  // Flags are dma, fetch, write, overrun, branch destination.
  localparam ubm_row_t ROWS [11] = '{
    '{32'h0000_0404, 8'h54, 32'h0000_0404, 5'b01000, 2'h2, 1'b1},
    '{32'h0015_389C, 8'h58, 32'h0015_389C, 5'b01000, 2'h2, 1'b0},
    '{32'h0003_0147, 8'h54, 32'h0003_0146, 5'b01000, 2'h2, 1'b0},
    '{32'h0012_3456, 8'h6A, 32'h0012_3456, 5'b00100, 2'h2, 1'b1},
    '{32'h00A8_0391, 8'h66, 32'h00A8_0390, 5'b00000, 2'h2, 1'b0},
    '{32'h0076_BCDC, 8'hA7, 32'h0076_BCDC, 5'b10000, 2'h3, 1'b1},
    '{32'h0023_45C8, 8'h94, 32'h0023_45C8, 5'b10000, 2'h2, 1'b0},
    '{32'h0000_0500, 8'h14, 32'h0000_0500, 5'b01000, 2'h2, 1'b0},
    '{32'h0000_0600, 8'h54, 32'h0000_0600, 5'b01010, 2'h2, 1'b0},
    '{32'h0000_0700, 8'h74, 32'h0000_0700, 5'b01010, 2'h2, 1'b1},
    '{32'h0000_0800, 8'h54, 32'h0000_0800, 5'b01001, 2'h2, 1'b0}
  };

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clkEn = 1'b1;
  logic [15:0] breakAddressHigh = 16'h0000;
  logic [15:0] breakAddressLow = 16'h0000;
  logic [7:0]  breakCycleSelect = 8'h00;
  logic        busValid = 1'b0;
  logic        busDma = 1'b0;
  logic        busFetch = 1'b0;
  logic        busWrite = 1'b0;
  logic [1:0]  busSize = 2'h2;
  logic [31:0] busAddr = 32'h0000_0000;
  logic        fetchPair = 1'b0;
  logic        fetchOverrun = 1'b0;
  logic        fetchBranchDest = 1'b0;
  logic [3:0]  coreMaskLevel = 4'h0;
  logic        breakAck;
  logic        higherExcDecode = 1'b0;
  logic        breakRequest;
  logic [3:0]  breakLevel;
  logic        breakAcceptable;
  logic [31:0] breakPc;
  int          fails = 0;
  int          total_checks = 0;

  always #4 sys_clk = ~sys_clk;

  ubm_breakpoint_matcher ubm_breakpoint_matcher_i
  (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .clkEn            (clkEn),
    .breakAddressHigh (breakAddressHigh),
    .breakAddressLow  (breakAddressLow),
    .breakCycleSelect (breakCycleSelect),
    .busValid         (busValid),
    .busDma           (busDma),
    .busFetch         (busFetch),
    .busWrite         (busWrite),
    .busSize          (busSize),
    .busAddr          (busAddr),
    .fetchPair        (fetchPair),
    .fetchOverrun     (fetchOverrun),
    .fetchBranchDest  (fetchBranchDest),
    .coreMaskLevel    (coreMaskLevel),
    .breakAck         (breakAck),
    .higherExcDecode  (higherExcDecode),
    .breakRequest     (breakRequest),
    .breakLevel       (breakLevel),
    .breakAcceptable  (breakAcceptable),
    .breakPc          (breakPc)
  );

  ubm_core_model #(.DELAY(1)) ubm_core_model_i
  (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .breakAcceptable  (breakAcceptable),
    .breakAck         (breakAck)
  );

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ************************************************************
  // One bus cycle, presented just after an edge and taken at the next
  // ************************************************************
  task automatic cyc(input logic [31:0] a, input logic [4:0] f,
                     input logic [1:0] s, input logic p,
                     input logic more);
    busValid  = 1'b1;
    busAddr   = a;
    busSize   = s;
    fetchPair = p;
    {busDma, busFetch, busWrite, fetchOverrun, fetchBranchDest} = f;
    @(posedge sys_clk);
    #1;
    // Back-to-back cycles keep the strobe up so it is set once per step.
    if (!more)
    begin
      busValid        = 1'b0;
      fetchPair       = 1'b0;
      fetchOverrun    = 1'b0;
      fetchBranchDest = 1'b0;
    end
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (breakRequest !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (breakRequest !== 1'b0)
    begin
      fails++;
      $display("Error breakRequest expected 0 seen stuck");
      end_of_test();
    end
  endtask

  task automatic arm(input logic [31:0] t, input logic [7:0] s);
    {breakAddressHigh, breakAddressLow} = t;
    breakCycleSelect = s;
  endtask

  // ************************************************************
  // Fetches of a taken branch: branch, two more, then the destination
  // ************************************************************
  task automatic fetch_run(input logic [31:0] b, input logic [31:0] d,
                           input logic dly);
    cyc(b, 5'b01000, 2'h2, 1'b0, 1'b1);
    cyc(b + FETCH_STEP, dly ? 5'b01000 : 5'b01010, 2'h2, 1'b0, 1'b1);
    cyc(b + FETCH_STEP + FETCH_STEP, 5'b01010, 2'h2, 1'b0, 1'b1);
    cyc(d, dly ? 5'b01000 : 5'b01001, 2'h2, 1'b0, 1'b0);
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    chk("breakRequest", 32'h0, breakRequest);
    chk("breakPc", 32'h0, breakPc);
    chk("breakLevel", 32'hF, breakLevel);
    chk("breakAcceptable", 32'h0, breakAcceptable);
    foreach (ROWS[i])
    begin
      arm(ROWS[i].tgt, ROWS[i].sel);
      cyc(ROWS[i].adr, ROWS[i].flg, ROWS[i].sz, 1'b0, 1'b0);
      chk("breakRequest", ROWS[i].hit, breakRequest);
      if (ROWS[i].hit)
        chk("breakPc", ROWS[i].tgt, breakPc);
      wait_idle();
    end
    // A masked request must stay pending until something else clears it.
    coreMaskLevel = 4'hF;
    arm(32'h0000_0200, 8'h54);
    cyc(32'h0000_0200, 5'b01000, 2'h2, 1'b0, 1'b0);
    repeat (5) @(posedge sys_clk);
    #1;
    chk("breakRequest", 32'h1, breakRequest);
    chk("breakAcceptable", 32'h0, breakAcceptable);
    higherExcDecode = 1'b1;
    @(posedge sys_clk);
    #1;
    higherExcDecode = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("breakRequest", 32'h0, breakRequest);
    // Second instruction of a paired fetch, select changed right after.
    coreMaskLevel = 4'hE;
    arm(32'h0000_0302, 8'h54);
    cyc(32'h0000_0300, 5'b01000, 2'h2, 1'b1, 1'b0);
    breakCycleSelect = 8'h00;
    chk("breakRequest", 32'h1, breakRequest);
    chk("breakPc", 32'h0000_0302, breakPc);
    chk("breakAcceptable", 32'h1, breakAcceptable);
    wait_idle();
    // Enable low freezes a pending break; reset clears it regardless.
    coreMaskLevel = 4'hF;
    arm(32'h0000_0200, 8'h54);
    cyc(32'h0000_0200, 5'b01000, 2'h2, 1'b0, 1'b0);
    clkEn = 1'b0;
    higherExcDecode = 1'b1;
    @(posedge sys_clk);
    #1;
    higherExcDecode = 1'b0;
    chk("breakRequest", 32'h1, breakRequest);
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    clkEn = 1'b1;
    coreMaskLevel = 4'hE;
    chk("breakRequest", 32'h0, breakRequest);
    chk("breakAcceptable", 32'h0, breakAcceptable);
    chk("breakPc", 32'h0, breakPc);
    chk("breakLevel", 32'hF, breakLevel);
    // Non-delayed branch: the second overrun hits the target address.
    arm(32'h0000_0904, 8'h54);
    fetch_run(32'h0000_0900, 32'h0000_0A00, 1'b0);
    chk("breakRequest", 32'h0, breakRequest);
    wait_idle();
    // With data breaks also selected the same overrun does break.
    arm(32'h0000_0904, 8'h74);
    fetch_run(32'h0000_0900, 32'h0000_0A00, 1'b0);
    chk("breakRequest", 32'h1, breakRequest);
    chk("breakPc", 32'h0000_0904, breakPc);
    wait_idle();
    // Delayed branch: the destination is a real fetch and may break.
    arm(32'h0000_0C00, 8'h54);
    fetch_run(32'h0000_0B00, 32'h0000_0C00, 1'b1);
    chk("breakRequest", 32'h1, breakRequest);
    chk("breakPc", 32'h0000_0C00, breakPc);
    wait_idle();
    end_of_test();
  end
endmodule // ubm_breakpoint_matcher_tb

// ### tb/ubm_core_model.sv
`timescale 1ns/1ns
// ************************************************************
// Core and interrupt controller answering a pending break
// ************************************************************
module ubm_core_model
  import ubm_pkg::*;
#(
  parameter int DELAY = 1
)
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic breakAcceptable,
  output logic      breakAck
);
  int cnt;

  // The core only takes the request once the mask allows it, and it waits
  // for an instruction boundary, which is modelled as a fixed delay.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cnt      <= 0;
      breakAck <= 1'b0;
    end
    else if (breakAcceptable && !breakAck && cnt == DELAY)
    begin
      cnt      <= 0;
      breakAck <= 1'b1;
    end
    else
    begin
      cnt      <= breakAcceptable && !breakAck ? cnt + 1 : 0;
      breakAck <= 1'b0;
    end
  end
endmodule // ubm_core_model
